// File: verilog/fcd_regs.vh
// Constants for the command set decoder: opcodes, field positions, counts and reset values
`ifndef FCD_REGS_VH
`define FCD_REGS_VH
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define FCD_OP_SCAN_LE      5'h19
`define FCD_OP_VERIFY       5'h16
`define FCD_OP_WRITE        6'h05
`define FCD_OP_WRITE_DEL    6'h09
`define FCD_OP_SEEK         8'h0f
`define FCD_OP_SENSE_DRIVE  8'h04
`define FCD_OP_SENSE_INT    8'h08
`define FCD_OP_SPECIFY      8'h03
`define FCD_OP_VERSION      8'h10
`define FCD_OP_SET_TRACK    6'h21
`define FCD_SET_TRACK_TAG   5'h06
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCD_BIT_OPTION      7
`define FCD_BIT_HEAD        2
`define FCD_BIT_WNR         6
`define FCD_BIT_MSB_SEL     2
// ----------------------------------------
// Byte counts
// ----------------------------------------
`define FCD_LEN_XFER        4'h9
`define FCD_LEN_SEEK        4'h3
`define FCD_LEN_SEEK_ETR    4'h4
`define FCD_LEN_TWO         4'h2
`define FCD_LEN_THREE       4'h3
`define FCD_RES_XFER        4'h7
// ----------------------------------------
// Identification and reset values
// ----------------------------------------
// Identification byte value is arbitrary
`define FCD_VERSION_ID      8'h5a
`define FCD_RST_BYTE        8'h00
`endif

// File: verilog/fcd_decoder.v
// Floppy controller command set decoder: command, execution and result phases
// Overview of operation
// - Scan low-or-equal decoded; host bytes compared with disk
// - Scan, verify, write take nine command bytes
// - Seek takes three bytes, steps, no result
// - Extended range seek adds fourth upper-nibble byte
// - Sense drive status returns status register three
// - Sense interrupt returns status zero, track low
// - Third sense interrupt byte only when extended
// - Set track reads or writes present track byte
// - Specify stores step, motor off, motor on
// - Verify reads sectors, count or length option
// - Write data takes host data, seven results
// - Write deleted records deleted mark, seven results
// - Implied seek precedes transfer when enabled
`timescale 1ns/10ps
`default_nettype none
`include "fcd_regs.vh"
module fcd_decoder
(
	input  wire        core_clk,
	input  wire        rst,
	input  wire        cmd_valid,
	input  wire [7:0]  cmd_byte,
	output wire        cmd_ready,
	output wire        res_valid,
	output reg  [7:0]  res_byte_ff,
	input  wire        res_ready,
	input  wire        extended_track_range,
	input  wire        implied_seek_enable,
	input  wire [7:0]  drive_status,
	input  wire [7:0]  st0_in,
	input  wire [7:0]  st1_in,
	input  wire [7:0]  st2_in,
	input  wire        host_data_valid,
	input  wire [7:0]  host_data,
	input  wire        disk_data_valid,
	input  wire [7:0]  disk_data,
	input  wire        exec_done,
	output reg         exec_start_ff,
	output reg  [3:0]  exec_kind_ff,
	output reg         seek_start_ff,
	output reg  [1:0]  drive_sel_ff,
	output reg         head_sel_ff,
	output reg  [11:0] target_track_ff,
	output reg         deleted_mark_ff,
	output reg         pass_to_host_ff,
	output reg         count_mode_flag_ff,
	output reg         multi_track_flag_ff,
	output reg         double_density_select_ff,
	output reg         skip_deleted_flag_ff,
	output reg  [3:0]  step_rate_ff,
	output reg  [3:0]  motor_off_ff,
	output reg  [7:0]  motor_on_ff,
	output reg         scan_hit_ff,
	output reg  [7:0]  param_track_ff,
	output reg  [7:0]  param_head_ff,
	output reg  [7:0]  param_sector_ff,
	output reg  [7:0]  param_size_ff,
	output reg  [7:0]  param_last_ff,
	output reg  [7:0]  param_gap_ff,
	output reg  [7:0]  param_length_ff
);
// ----------------------------------------
// States and command kinds
// ----------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_CMD  = 3'h1;
localparam ST_ISK  = 3'h2;
localparam ST_EXEC = 3'h3;
localparam ST_RES  = 3'h4;
localparam K_SCAN  = 4'h0;
localparam K_SEEK  = 4'h1;
localparam K_SDS   = 4'h2;
localparam K_SINT  = 4'h3;
localparam K_STRK  = 4'h4;
localparam K_SPEC  = 4'h5;
localparam K_VER   = 4'h6;
localparam K_VFY   = 4'h7;
localparam K_WR    = 4'h8;
localparam K_WRD   = 4'h9;
localparam K_BAD   = 4'hf;
reg  [2:0]  state_ff;
reg  [3:0]  cnt_ff;
reg  [3:0]  len_ff;
reg  [3:0]  res_len_ff;
reg  [11:0] ptr_ff [0:3];
reg  [7:0]  res_buf_ff [0:6];
reg         wnr_ff;
reg         msb_sel_ff;
wire        take = cmd_valid & cmd_ready;
wire        give = res_valid & res_ready;
wire [11:0] cur_ptr = ptr_ff[drive_sel_ff];
assign cmd_ready = (state_ff == ST_IDLE) | (state_ff == ST_CMD);
assign res_valid = (state_ff == ST_RES);
// ----------------------------------------
// Opcode decode
// ----------------------------------------
reg [3:0] dec_kind;
reg [3:0] dec_len;
always @*
begin
	dec_kind = K_BAD;
	if (cmd_byte[4:0] == `FCD_OP_SCAN_LE)
		dec_kind = K_SCAN;
	else if (cmd_byte[4:0] == `FCD_OP_VERIFY)
		dec_kind = K_VFY;
	else if (cmd_byte[5:0] == `FCD_OP_WRITE)
		dec_kind = K_WR;
	else if (cmd_byte[5:0] == `FCD_OP_WRITE_DEL)
		dec_kind = K_WRD;
	else if (cmd_byte == `FCD_OP_SEEK)
		dec_kind = K_SEEK;
	else if (cmd_byte == `FCD_OP_SENSE_DRIVE)
		dec_kind = K_SDS;
	else if (cmd_byte == `FCD_OP_SENSE_INT)
		dec_kind = K_SINT;
	else if (cmd_byte == `FCD_OP_SPECIFY)
		dec_kind = K_SPEC;
	else if (cmd_byte == `FCD_OP_VERSION)
		dec_kind = K_VER;
	else if (!cmd_byte[7] && cmd_byte[5:0] == `FCD_OP_SET_TRACK)
		dec_kind = K_STRK;
	// Length follows the kind so the two can never disagree
	case (dec_kind)
	K_SCAN, K_VFY, K_WR, K_WRD: dec_len = `FCD_LEN_XFER;
	K_SEEK:                     dec_len = extended_track_range ? `FCD_LEN_SEEK_ETR : `FCD_LEN_SEEK;
	K_SDS:                      dec_len = `FCD_LEN_TWO;
	K_SPEC, K_STRK:             dec_len = `FCD_LEN_THREE;
	default:                    dec_len = 4'h1;
	endcase
end
// ----------------------------------------
// Phase sequencer
// ----------------------------------------
wire xfer_kind = (exec_kind_ff == K_SCAN) | (exec_kind_ff == K_VFY) |
                 (exec_kind_ff == K_WR) | (exec_kind_ff == K_WRD);
wire last_cmd  = take & (cnt_ff + 4'h1 == len_ff);
integer i;
always @(posedge core_clk)
begin
	exec_start_ff <= 1'b0;
	seek_start_ff <= 1'b0;
	if (rst)
	begin
		state_ff                 <= ST_IDLE;
		cnt_ff                   <= 4'h0;
		len_ff                   <= 4'h1;
		res_len_ff               <= 4'h0;
		exec_kind_ff             <= K_BAD;
		drive_sel_ff             <= 2'h0;
		head_sel_ff              <= 1'b0;
		target_track_ff          <= 12'h000;
		deleted_mark_ff          <= 1'b0;
		pass_to_host_ff          <= 1'b0;
		count_mode_flag_ff       <= 1'b0;
		multi_track_flag_ff      <= 1'b0;
		double_density_select_ff <= 1'b0;
		skip_deleted_flag_ff     <= 1'b0;
		step_rate_ff             <= 4'h0;
		motor_off_ff             <= 4'h0;
		motor_on_ff              <= `FCD_RST_BYTE;
		scan_hit_ff              <= 1'b1;
		wnr_ff                   <= 1'b0;
		msb_sel_ff               <= 1'b0;
		res_byte_ff              <= `FCD_RST_BYTE;
		param_track_ff           <= `FCD_RST_BYTE;
		param_head_ff            <= `FCD_RST_BYTE;
		param_sector_ff          <= `FCD_RST_BYTE;
		param_size_ff            <= `FCD_RST_BYTE;
		param_last_ff            <= `FCD_RST_BYTE;
		param_gap_ff             <= `FCD_RST_BYTE;
		param_length_ff          <= `FCD_RST_BYTE;
		for (i = 0; i < 4; i = i + 1)
			ptr_ff[i] <= 12'h000;
		for (i = 0; i < 7; i = i + 1)
			res_buf_ff[i] <= `FCD_RST_BYTE;
	end
	else
	begin
		case (state_ff)
		ST_IDLE:
			if (take)
			begin
				exec_kind_ff             <= dec_kind;
				len_ff                   <= dec_len;
				cnt_ff                   <= 4'h1;
				multi_track_flag_ff      <= cmd_byte[7];
				double_density_select_ff <= cmd_byte[6];
				skip_deleted_flag_ff     <= cmd_byte[5];
				wnr_ff                   <= cmd_byte[`FCD_BIT_WNR];
				deleted_mark_ff          <= (dec_kind == K_WRD);
				pass_to_host_ff          <= 1'b0;
				scan_hit_ff              <= 1'b1;
				state_ff                 <= (dec_len == 4'h1) ? ST_EXEC : ST_CMD;
			end
		ST_CMD:
			if (take)
			begin
				cnt_ff <= cnt_ff + 4'h1;
				case (cnt_ff)
				4'h1:
				begin
					drive_sel_ff       <= cmd_byte[1:0];
					head_sel_ff        <= cmd_byte[`FCD_BIT_HEAD];
					msb_sel_ff         <= cmd_byte[`FCD_BIT_MSB_SEL];
					count_mode_flag_ff <= cmd_byte[`FCD_BIT_OPTION];
					// Only specify may touch the drive timings
					motor_off_ff       <= (exec_kind_ff == K_SPEC) ? cmd_byte[3:0] : motor_off_ff;
					step_rate_ff       <= (exec_kind_ff == K_SPEC) ? cmd_byte[7:4] : step_rate_ff;
				end
				4'h2:
				begin
					param_track_ff  <= cmd_byte;
					motor_on_ff     <= (exec_kind_ff == K_SPEC) ? cmd_byte : motor_on_ff;
					target_track_ff <= {target_track_ff[11:8], cmd_byte};
					if (exec_kind_ff == K_SEEK && !extended_track_range)
						target_track_ff <= {4'h0, cmd_byte};
				end
				4'h3:
				begin
					param_head_ff   <= cmd_byte;
					target_track_ff <= (exec_kind_ff == K_SEEK) ? {cmd_byte[7:4], target_track_ff[7:0]} : target_track_ff;
				end
				4'h4: param_sector_ff <= cmd_byte;
				4'h5: param_size_ff   <= cmd_byte;
				4'h6: param_last_ff   <= cmd_byte;
				4'h7: param_gap_ff    <= cmd_byte;
				4'h8: param_length_ff <= cmd_byte;
				default: ;
				endcase
				if (last_cmd)
				begin
					// Implied seek brings the head to the track before the transfer runs
					cnt_ff   <= 4'h0;
					state_ff <= (xfer_kind && implied_seek_enable) ? ST_ISK : ST_EXEC;
				end
			end
		ST_ISK:
		begin
			// One seek per command; cnt_ff marks it issued while the drive works
			if (cnt_ff == 4'h0)
			begin
				seek_start_ff   <= 1'b1;
				target_track_ff <= {4'h0, param_track_ff};
				cnt_ff          <= 4'h1;
			end
			else if (exec_done)
			begin
				ptr_ff[drive_sel_ff] <= {4'h0, param_track_ff};
				cnt_ff               <= 4'h0;
				state_ff             <= ST_EXEC;
			end
		end
		ST_EXEC:
		begin
			cnt_ff <= 4'h0;
			state_ff <= ST_RES;
			case (exec_kind_ff)
			K_SEEK:
			begin
				seek_start_ff        <= 1'b1;
				ptr_ff[drive_sel_ff] <= target_track_ff;
				state_ff             <= ST_IDLE;
			end
			K_SPEC: state_ff <= ST_IDLE;
			K_SDS:
			begin
				res_buf_ff[0] <= drive_status;
				res_len_ff    <= 4'h1;
			end
			K_SINT:
			begin
				res_buf_ff[0] <= st0_in;
				res_buf_ff[1] <= cur_ptr[7:0];
				res_buf_ff[2] <= {cur_ptr[11:8], 4'h0};
				res_len_ff    <= extended_track_range ? 4'h3 : 4'h2;
			end
			K_STRK:
			begin
				if (wnr_ff && msb_sel_ff)
					ptr_ff[drive_sel_ff] <= {param_track_ff[3:0], cur_ptr[7:0]};
				else if (wnr_ff)
					ptr_ff[drive_sel_ff] <= {cur_ptr[11:8], param_track_ff};
				res_buf_ff[0] <= wnr_ff ? param_track_ff :
				                 (msb_sel_ff ? {4'h0, cur_ptr[11:8]} : cur_ptr[7:0]);
				res_len_ff    <= 4'h1;
			end
			K_VER:
			begin
				res_buf_ff[0] <= `FCD_VERSION_ID;
				res_len_ff    <= 4'h1;
			end
			K_SCAN, K_VFY, K_WR, K_WRD:
			begin
				state_ff <= ST_EXEC;
				if (cnt_ff == 4'h0)
					exec_start_ff <= 1'b1;
				cnt_ff <= 4'h1;
				// Low-or-equal holds only while every host byte is at or below the disk byte
				if (exec_kind_ff == K_SCAN && host_data_valid && disk_data_valid && host_data > disk_data)
					scan_hit_ff <= 1'b0;
				if (exec_done && cnt_ff == 4'h1)
				begin
					res_buf_ff[0] <= st0_in;
					res_buf_ff[1] <= st1_in;
					res_buf_ff[2] <= st2_in;
					res_buf_ff[3] <= param_track_ff;
					res_buf_ff[4] <= param_head_ff;
					res_buf_ff[5] <= param_sector_ff;
					res_buf_ff[6] <= param_size_ff;
					res_len_ff    <= `FCD_RES_XFER;
					cnt_ff        <= 4'h0;
					state_ff      <= ST_RES;
				end
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
		ST_RES:
		begin
			res_byte_ff <= res_buf_ff[cnt_ff[2:0]];
			if (give)
			begin
				cnt_ff      <= cnt_ff + 4'h1;
				if (cnt_ff + 4'h1 == res_len_ff)
					state_ff <= ST_IDLE;
			end
		end
		default: state_ff <= ST_IDLE;
		endcase
	end
end
endmodule
`default_nettype wire

// File: bench/fcd_decoder_checker.sv
// Concurrent checks on the command set decoder ports
`timescale 1ns/10ps
`default_nettype none
`include "fcd_regs.vh"
module fcd_decoder_checker
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       cmd_ready,
	input wire logic       res_valid,
	input wire logic [7:0] res_byte_ff,
	input wire logic [7:0] drive_status,
	input wire logic       implied_seek_enable,
	input wire logic       exec_start_ff,
	input wire logic       seek_start_ff,
	input wire logic [3:0] exec_kind_ff,
	input wire logic       deleted_mark_ff,
	input wire logic       pass_to_host_ff,
	input wire logic       scan_hit_ff,
	input wire logic       host_data_valid,
	input wire logic [7:0] host_data,
	input wire logic       disk_data_valid,
	input wire logic [7:0] disk_data
);
	logic seek_seen_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Remembers a seek issued since the last transfer start
	always_ff @(posedge core_clk)
		seek_seen_ff <= rst ? 1'b0 : (seek_start_ff ? 1'b1 : (exec_start_ff ? 1'b0 : seek_seen_ff));
	a_exec_pulse_once:
		assert property (exec_start_ff |=> !exec_start_ff) else $error("transfer start pulse too long");
	a_seek_pulse_once:
		assert property (seek_start_ff |=> !seek_start_ff) else $error("seek start pulse too long");
	a_seek_no_result:
		assert property (seek_start_ff && exec_kind_ff == 4'h1 |-> cmd_ready && !res_valid ##1 !res_valid)
			else $error("seek gave result");
	a_exec_refuses_cmd:
		assert property (exec_start_ff |-> !cmd_ready [*3]) else $error("command taken during execution");
	a_verify_no_host:
		assert property (!pass_to_host_ff) else $error("data passed to host");
	a_version_byte:
		assert property ($rose(res_valid) && exec_kind_ff == 4'h6 |=> res_byte_ff == `FCD_VERSION_ID)
			else $error("wrong identification byte");
	a_drive_status_byte:
		assert property ($rose(res_valid) && exec_kind_ff == 4'h2 |=> res_byte_ff == drive_status)
			else $error("wrong drive status byte");
	a_deleted_mark_kind:
		assert property (exec_start_ff |-> deleted_mark_ff == (exec_kind_ff == 4'h9)) else $error("deleted mark wrong");
	a_implied_seek_first:
		assert property (exec_start_ff && implied_seek_enable |-> seek_seen_ff) else $error("no implied seek");
	a_scan_hit_drop:
		assert property (exec_kind_ff == 4'h0 && host_data_valid && disk_data_valid && host_data > disk_data
			|-> ##[1:2] !scan_hit_ff) else $error("scan miss not flagged");
	c_write_deleted: cover property (exec_start_ff && exec_kind_ff == 4'h9);
	c_implied_seek: cover property (seek_start_ff && implied_seek_enable);
	c_sense_int: cover property ($rose(res_valid) && exec_kind_ff == 4'h3);
endmodule
bind fcd_decoder fcd_decoder_checker i_chk (.core_clk(core_clk), .rst(rst), .cmd_ready(cmd_ready),
	.res_valid(res_valid), .res_byte_ff(res_byte_ff), .drive_status(drive_status),
	.implied_seek_enable(implied_seek_enable), .exec_start_ff(exec_start_ff), .seek_start_ff(seek_start_ff),
	.exec_kind_ff(exec_kind_ff), .deleted_mark_ff(deleted_mark_ff), .pass_to_host_ff(pass_to_host_ff),
	.scan_hit_ff(scan_hit_ff), .host_data_valid(host_data_valid), .host_data(host_data),
	.disk_data_valid(disk_data_valid), .disk_data(disk_data));
`default_nettype wire

// File: bench/fcd_drive_model.sv
// Drive-side model: ends seeks and transfers and streams disk bytes
`timescale 1ns/10ps
`default_nettype none
module fcd_drive_model
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       exec_start,
	input  wire logic       seek_start,
	output var  logic       exec_done,
	output var  logic       stream_valid,
	output var  logic [7:0] disk_data
);
	logic [7:0] left_ff;
	// Slow mode stretches execution so refusals are seen over a long window
	always_ff @(posedge core_clk)
	begin
		exec_done    <= 1'b0;
		stream_valid <= 1'b0;
		// Outside a stream the bytes toggle so a stale value never passes as data
		disk_data    <= disk_data ^ 8'hff;
		if (rst)
		begin
			left_ff   <= 8'h00;
			disk_data <= 8'h00;
		end
		else if (exec_start || seek_start)
			left_ff <= slow ? 8'h28 : 8'h06;
		else if (left_ff != 8'h00)
		begin
			left_ff <= left_ff - 8'h01;
			if (left_ff >= 8'h02 && left_ff <= 8'h05)
			begin
				stream_valid <= 1'b1;
				disk_data    <= 8'h40;
			end
			if (left_ff == 8'h01)
				exec_done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: bench/fcd_decoder_tb.sv
// Self-checking bench for the command set decoder
`timescale 1ns/10ps
`default_nettype none
`include "fcd_regs.vh"
module fcd_decoder_tb;
	logic       core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, res_ready = 1'b0;
	logic       ext_range = 1'b0, imp_seek = 1'b0, slow = 1'b0;
	logic [7:0] cmd_byte = 8'h00, drive_status = 8'h6b, host_d = 8'h50, rb;
	wire logic  cmd_ready, res_valid, exec_done, exec_start, seek_start, strm, del_mark, cmode, mt, hit, head;
	wire logic [7:0]  res_byte, disk_d, mon;
	wire logic [3:0]  kind, step, moff;
	wire logic [1:0]  dsel;
	wire logic [11:0] track;
	int failures = 0, checked = 0, cycles = 0, seeks = 0, s0;
	fcd_decoder i_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_ready(cmd_ready), .res_valid(res_valid), .res_byte_ff(res_byte), .res_ready(res_ready),
		.extended_track_range(ext_range), .implied_seek_enable(imp_seek), .drive_status(drive_status),
		.st0_in(8'h41), .st1_in(8'h02), .st2_in(8'h10), .host_data_valid(strm), .host_data(host_d),
		.disk_data_valid(strm), .disk_data(disk_d), .exec_done(exec_done), .exec_start_ff(exec_start),
		.exec_kind_ff(kind), .seek_start_ff(seek_start), .drive_sel_ff(dsel), .head_sel_ff(head),
		.target_track_ff(track), .deleted_mark_ff(del_mark), .pass_to_host_ff(), .count_mode_flag_ff(cmode),
		.multi_track_flag_ff(mt), .double_density_select_ff(), .skip_deleted_flag_ff(), .step_rate_ff(step),
		.motor_off_ff(moff), .motor_on_ff(mon), .scan_hit_ff(hit), .param_track_ff(), .param_head_ff(),
		.param_sector_ff(), .param_size_ff(), .param_last_ff(), .param_gap_ff(), .param_length_ff());
	fcd_drive_model i_drive (.core_clk(core_clk), .rst(rst), .slow(slow), .exec_start(exec_start),
		.seek_start(seek_start), .exec_done(exec_done), .stream_valid(strm), .disk_data(disk_d));
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		seeks += seek_start;
		if (++cycles == 20000)
		begin
			failures++;
			end_sim;
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Bytes go out most significant first; valid is held until the byte is taken
	task automatic run(input int n, input logic [71:0] v);
		int k;
		for (int i = 0; i < n; i++)
		begin
			cmd_valid = 1'b1;
			cmd_byte = v[8*(n-1-i) +: 8];
			for (k = 0; cmd_ready !== 1'b1 && k < 100; k++) wt(1);
			wt(1);
		end
		cmd_valid = 1'b0;
	endtask
	// The byte is trusted from the second cycle of valid only
	task automatic res(input int n, input logic [55:0] v);
		int k;
		for (int i = 0; i < n; i++)
		begin
			for (k = 0; res_valid !== 1'b1 && k < 200; k++) wt(1);
			wt(1);
			chk(res_byte, v[8*(n-1-i) +: 8], "result byte");
			res_ready = 1'b1;
			wt(1);
			res_ready = 1'b0;
		end
	endtask
	task automatic end_sim;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	localparam logic [31:0] OPS = 32'hd956c549;
	localparam logic [15:0] KINDS = 16'h0789;
	initial
	begin
		wt(8);
		rst = 1'b0;
		run(1, 8'h10);
		res(1, `FCD_VERSION_ID);
		run(3, 24'h03a53c);
		wt(3);
		chk({step, moff, mon}, 16'ha53c, "specify times");
		chk(res_valid, 1'b0, "specify result");
		run(3, 24'h0f0527);
		wt(2);
		chk({dsel, head, track}, {2'h1, 1'b1, 12'h027}, "seek target");
		ext_range = 1'b1;
		slow = 1'b1;
		run(4, 32'h0f023450);
		wt(2);
		chk(track, 12'h534, "extended seek");
		run(1, 8'h08);
		res(3, 24'h413450);
		ext_range = 1'b0;
		slow = 1'b0;
		run(1, 8'h08);
		res(2, 16'h4134);
		wt(2);
		chk(res_valid, 1'b0, "no third byte");
		for (int i = 0; i < 2; i++)
		begin
			drive_status = i ? 8'h94 : 8'h6b;
			run(2, 16'h0406);
			res(1, drive_status);
		end
		run(3, 24'h613177);
		res(1, 8'h77);
		run(3, 24'h613505);
		res(1, 8'h05);
		run(3, 24'h213100);
		res(1, 8'h77);
		run(3, 24'h213500);
		res(1, 8'h05);
		for (int i = 0; i < 4; i++)
		begin
			run(9, {OPS[31-8*i -: 8], (i == 1) ? 8'h86 : 8'h06, 56'h12010302091bff});
			res(7, 56'h41021012010302);
			chk({kind, del_mark, cmode, mt, dsel}, {KINDS[15-4*i -: 4], i == 3, i == 1, OPS[31-8*i], 2'h2}, "fields");
			if (i == 0) chk(hit, 1'b0, "scan above disk");
		end
		host_d = 8'h20;
		slow = 1'b1;
		run(9, 72'hd90612010302091bff);
		res(7, 56'h41021012010302);
		chk(hit, 1'b1, "scan below disk");
		imp_seek = 1'b1;
		s0 = seeks;
		run(9, 72'hc50612010302091bff);
		res(7, 56'h41021012010302);
		chk(seeks - s0, 12'h1, "implied seek");
		end_sim;
	end
endmodule
`default_nettype wire
